/* logic/rpd_map.svh */
// Register offsets, field positions, reset values and widths of the rotor position detector
`ifndef RPD_MAP_SVH
`define RPD_MAP_SVH

`define RPD_OFS_CTRL_A      8'h00
`define RPD_OFS_CTRL_B      8'h04
`define RPD_OFS_STATUS      8'h08
`define RPD_OFS_PATTERN     8'h0C
`define RPD_OFS_DELAY       8'h10

`define RPD_CA_SOFT_STOP    7
`define RPD_CA_SOFT_START   6
`define RPD_ST_EDGE_LSB     4
`define RPD_ST_SAMPLING     3

`define RPD_RST_CTRL_A      6'h00
`define RPD_RST_CTRL_B      8'h00
`define RPD_RST_PATTERN     3'h0
`define RPD_RST_DELAY       8'h00

`define RPD_PRE_BASE        6'h04
`define RPD_ONE_PIN_MASK    3'h1
`define RPD_ALL_PIN_MASK    3'h7

`endif

/* logic/rpd_pkg.sv */
// Types shared by the rotor position detector files
package rpd_pkg;

  // Sampling gate choices
  typedef enum logic [1:0] {
    RPD_GATE_PWM   = 2'h0,
    RPD_GATE_CONT  = 2'h1,
    RPD_GATE_LOWER = 2'h2,
    RPD_GATE_RSVD  = 2'h3
  } rpd_gate_e;

  // Sequencer states, Gray coded along idle, sample, final
  typedef enum logic [1:0] {
    RPD_IDLE   = 2'h0,
    RPD_SAMPLE = 2'h1,
    RPD_FINAL  = 2'h3
  } rpd_state_e;

  // Control register A, stored bits 5..0
  typedef struct packed {
    logic tmr3_stop_en;
    logic tmr2_start_en;
    logic one_pin;
    logic recount_per_pulse_enable;
    logic detect_mode_select;
    logic det_enable;
  } rpd_ctrl_a_s;

  // Control register B
  typedef struct packed {
    logic [1:0] sample_period_select;
    rpd_gate_e  sampling_gate_select;
    logic [3:0] match_count_setting;
  } rpd_ctrl_b_s;

endpackage : rpd_pkg

/* logic/rpd_sync.sv */
// Two-stage synchroniser for the three position pins
`timescale 1ns/1ps
module rpd_sync (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] async_i,
  output logic      [2:0] sync_o
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;

  // One chain per pin; the first stage feeds only the second
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_bit
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          meta_q[k] <= 1'b0;
          sync_q[k] <= 1'b0;
        end else if (ce_i) begin
          meta_q[k] <= async_i[k];
          sync_q[k] <= meta_q[k];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule : rpd_sync

/* logic/rpd_prescaler.sv */
// Sample tick generator: core clock divided by 4, 8, 16 or 32
`timescale 1ns/1ps
`include "rpd_map.svh"
module rpd_prescaler (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [1:0] period_sel_i,
  output logic            tick_o
);

  logic [4:0] cnt_q;
  logic [5:0] div;
  logic [4:0] last;

  // Divider length from the select field
  assign div  = 6'(`RPD_PRE_BASE << period_sel_i);
  assign last = 5'(div - 6'h01);

  // Free running; a period change takes effect at the next wrap or sooner
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
    end else if (ce_i) begin
      cnt_q <= (cnt_q >= last) ? 5'h00 : 5'(cnt_q + 5'h01);
    end
  end

  assign tick_o = ce_i && (cnt_q >= last);

endmodule : rpd_prescaler

/* logic/rpd_detector.sv */
// Rotor position detector top: APB registers, gating, match counting and detection
//
// Overview of operation
// - Ordinary mode detects when the sampled pins equal the expected drive pattern.
// - On ordinary detection, pulse the interrupt, end sampling, wait for a new start.
// - Unmatch mode latches the pins at start and detects any change from them.
// - Latched start pattern reads back in status bits 2 to 0.
// - Once enabled, sampling starts on a timer 2 trigger or software start.
// - With timer sync selected, timer 2 starts and timer 3 stops detection.
// - Three sampling gates: PWM-on only, continuous, or lower-side conduction.
// - Lower gating samples a phase from delay end until its conduction ends.
// - Lower gating samples phases independently; idle phases hold their last value.
// - Gated modes wait a programmable delay after turn-on before sampling.
// - Gated modes recount per PWM-on interval or count continuously; PWM-on ORs phases.
// - Status bit 5 records detection at PWM fall, bit 4 at PWM rise.
// - Status bit 3 reads whether sampling is in progress.
// - Two-bit field picks sample period of clock over 4, 8, 16 or 32.
// - Mode bit clear selects ordinary mode, set selects unmatch mode.
// - Software start begins sampling; software stop ends after one final comparison.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rpd_map.svh"
module rpd_detector (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        phase_u_position_in_i,
  input  wire logic        phase_v_position_in_i,
  input  wire logic        phase_w_position_in_i,
  input  wire logic [2:0]  pwm_phase_i,
  input  wire logic [2:0]  lower_on_i,
  input  wire logic        tmr2_evt_i,
  input  wire logic        tmr3_evt_i,
  output logic             position_match_irq_o,
  output logic             sampling_active_flag_o
);

  rpd_pkg::rpd_ctrl_a_s ctrl_a_q;
  rpd_pkg::rpd_ctrl_b_s ctrl_b_q;
  rpd_pkg::rpd_state_e  state_q;
  logic [2:0]  drive_pattern_register_q;
  logic [7:0]  delay_q;
  logic [31:0] prdata_q;
  logic [2:0]  pos_s;
  logic        tick;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [2:0]  start_pattern_latch_q;
  logic [2:0]  held_q;
  logic [2:0]  new_held;
  logic [3:0]  cnt_q;
  logic [4:0]  need;
  logic [1:0]  edge_detect_record_q;
  logic        irq_q;
  logic        pwm_on;
  logic        pwm_on_q;
  logic [3:0]  gate_src;
  logic [3:0]  gate_ok;
  logic [7:0]  dly_q [4];
  logic [2:0]  phase_en;
  logic [2:0]  mask;
  logic        hit;
  logic        hit_held;
  logic        hit_fin;
  logic        soft_start;
  logic        soft_stop;
  logic        start_go;
  logic        stop_go;
  logic        step;
  logic        detect;
  logic        gated;

  rpd_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .async_i    ({phase_w_position_in_i, phase_v_position_in_i, phase_u_position_in_i}),
    .sync_o     (pos_s)
  );

  rpd_prescaler u_pre (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .period_sel_i (ctrl_b_q.sample_period_select),
    .tick_o       (tick)
  );

  // APB decode; zero wait states, so the clock enable doubles as ready
  assign setup  = psel_i && !penable_i && ce_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && ce_i;
  assign mapped = (paddr_i == `RPD_OFS_CTRL_A) || (paddr_i == `RPD_OFS_CTRL_B) ||
                  (paddr_i == `RPD_OFS_STATUS) || (paddr_i == `RPD_OFS_PATTERN) ||
                  (paddr_i == `RPD_OFS_DELAY);
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o  = prdata_q;

  // Writable registers; status is read only and ignores writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_a_q                 <= rpd_pkg::rpd_ctrl_a_s'(`RPD_RST_CTRL_A);
      ctrl_b_q                 <= rpd_pkg::rpd_ctrl_b_s'(`RPD_RST_CTRL_B);
      drive_pattern_register_q <= `RPD_RST_PATTERN;
      delay_q                  <= `RPD_RST_DELAY;
    end else if (wr_acc) begin
      unique case (paddr_i)
        `RPD_OFS_CTRL_A:  ctrl_a_q <= rpd_pkg::rpd_ctrl_a_s'(pwdata_i[5:0]);
        `RPD_OFS_CTRL_B:  ctrl_b_q <= rpd_pkg::rpd_ctrl_b_s'(pwdata_i[7:0]);
        `RPD_OFS_PATTERN: drive_pattern_register_q <= pwdata_i[2:0];
        `RPD_OFS_DELAY:   delay_q <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup phase so it comes from a flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      unique case (paddr_i)
        `RPD_OFS_CTRL_A:  prdata_q <= {26'h000_0000, ctrl_a_q};
        `RPD_OFS_CTRL_B:  prdata_q <= {24'h00_0000, ctrl_b_q};
        `RPD_OFS_STATUS:  prdata_q <= {26'h000_0000, edge_detect_record_q, sampling_active_flag_o,
                                       start_pattern_latch_q};
        `RPD_OFS_PATTERN: prdata_q <= {29'h0000_0000, drive_pattern_register_q};
        `RPD_OFS_DELAY:   prdata_q <= {24'h00_0000, delay_q};
        default:          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Command strobes and start or stop triggers
  assign soft_start = wr_acc && (paddr_i == `RPD_OFS_CTRL_A) && pwdata_i[`RPD_CA_SOFT_START];
  assign soft_stop  = wr_acc && (paddr_i == `RPD_OFS_CTRL_A) && pwdata_i[`RPD_CA_SOFT_STOP];
  assign start_go   = ce_i && ctrl_a_q.det_enable && (state_q == rpd_pkg::RPD_IDLE) &&
                      (soft_start || (ctrl_a_q.tmr2_start_en && tmr2_evt_i));
  assign stop_go    = ce_i && (state_q == rpd_pkg::RPD_SAMPLE) &&
                      (soft_stop || (ctrl_a_q.tmr3_stop_en && tmr3_evt_i));

  // PWM-on is the OR of the three phase signals
  assign pwm_on   = |pwm_phase_i;
  assign gate_src = {pwm_on, lower_on_i};

  // Settle delay per gate source: counts from turn-on, restarts when the source drops
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dly
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          dly_q[g] <= 8'h00;
        end else if (ce_i) begin
          if (!gate_src[g]) begin
            dly_q[g] <= 8'h00;
          end else if (dly_q[g] != delay_q) begin
            dly_q[g] <= 8'(dly_q[g] + 8'h01);
          end
        end
      end
      assign gate_ok[g] = gate_src[g] && (dly_q[g] == delay_q);
    end
  endgenerate

  // Which phases take a fresh sample this tick
  always_comb begin
    unique case (ctrl_b_q.sampling_gate_select)
      rpd_pkg::RPD_GATE_PWM:   phase_en = {3{gate_ok[3]}};
      rpd_pkg::RPD_GATE_LOWER: phase_en = gate_ok[2:0];
      default:                 phase_en = 3'h7;
    endcase
  end

  assign gated = (ctrl_b_q.sampling_gate_select == rpd_pkg::RPD_GATE_PWM) ||
                 (ctrl_b_q.sampling_gate_select == rpd_pkg::RPD_GATE_LOWER);
  assign mask  = ctrl_a_q.one_pin ? `RPD_ONE_PIN_MASK : `RPD_ALL_PIN_MASK;

  // Idle phases keep their previous sample
  assign new_held = (phase_en & pos_s) | (~phase_en & held_q);
  assign step     = tick && (state_q == rpd_pkg::RPD_SAMPLE) && (phase_en != 3'h0);

  // Compare against expected pattern or start snapshot
  function automatic logic is_hit(input logic [2:0] v, input logic [2:0] exp_v,
                                  input logic [2:0] snap, input logic [2:0] m, input logic umode);
    is_hit = umode ? (((v ^ snap) & m) != 3'h0) : (((v ^ exp_v) & m) == 3'h0);
  endfunction : is_hit

  assign hit      = is_hit(new_held, drive_pattern_register_q, start_pattern_latch_q, mask,
                           ctrl_a_q.detect_mode_select);
  assign hit_held = is_hit(held_q, drive_pattern_register_q, start_pattern_latch_q, mask,
                           ctrl_a_q.detect_mode_select);
  assign hit_fin  = is_hit(pos_s, drive_pattern_register_q, start_pattern_latch_q, mask,
                           ctrl_a_q.detect_mode_select);

  // A setting of zero behaves as one
  assign need   = (ctrl_b_q.match_count_setting == 4'h0) ? 5'h01 : {1'b0, ctrl_b_q.match_count_setting};
  assign detect = (step && hit && (5'({1'b0, cnt_q} + 5'h01) >= need)) ||
                  (tick && (state_q == rpd_pkg::RPD_FINAL) && hit_fin);

  // Sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= rpd_pkg::RPD_IDLE;
    end else if (ce_i) begin
      unique case (state_q)
        rpd_pkg::RPD_IDLE: begin
          if (start_go) begin
            state_q <= rpd_pkg::RPD_SAMPLE;
          end
        end
        rpd_pkg::RPD_SAMPLE: begin
          if (detect) begin
            state_q <= rpd_pkg::RPD_IDLE;
          end else if (stop_go) begin
            state_q <= rpd_pkg::RPD_FINAL;
          end
        end
        rpd_pkg::RPD_FINAL: begin
          if (tick) begin
            state_q <= rpd_pkg::RPD_IDLE;
          end
        end
        default: state_q <= rpd_pkg::RPD_IDLE;
      endcase
    end
  end

  assign sampling_active_flag_o = (state_q != rpd_pkg::RPD_IDLE);

  // Start snapshot and held samples; snapshot taken every start so status stays fresh
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      start_pattern_latch_q <= 3'h0;
      held_q                <= 3'h0;
    end else if (start_go) begin
      start_pattern_latch_q <= pos_s;
      held_q                <= pos_s;
    end else if (ce_i && step) begin
      held_q <= new_held;
    end
  end

  // Consecutive hit counter; recount clears it while PWM is off
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else if (ce_i) begin
      if (start_go || detect) begin
        cnt_q <= 4'h0;
      end else if (gated && ctrl_a_q.recount_per_pulse_enable && !pwm_on) begin
        cnt_q <= 4'h0;
      end else if (step) begin
        cnt_q <= hit ? ((cnt_q == 4'hF) ? 4'hF : 4'(cnt_q + 4'h1)) : 4'h0;
      end
    end
  end

  // Interrupt request: one cycle per detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= detect;
    end else begin
      irq_q <= 1'b0;
    end
  end

  assign position_match_irq_o = irq_q;

  // Edge record: result at PWM fall sets bit 5, at rise bit 4; set beats the start clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pwm_on_q             <= 1'b0;
      edge_detect_record_q <= 2'h0;
    end else if (ce_i) begin
      pwm_on_q <= pwm_on;
      edge_detect_record_q[1] <= (pwm_on_q && !pwm_on && hit_held) ||
                                 (edge_detect_record_q[1] && !start_go);
      edge_detect_record_q[0] <= (!pwm_on_q && pwm_on && hit_held) ||
                                 (edge_detect_record_q[0] && !start_go);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  irq_one_cycle_a: assert property (position_match_irq_o |=> !position_match_irq_o)
    else $error("interrupt held longer than one cycle");
  detect_to_idle_a: assert property (ce_i && detect |=> position_match_irq_o && !sampling_active_flag_o)
    else $error("detection did not end sampling with an interrupt");
  ordinary_match_a: assert property (step && detect && !ctrl_a_q.detect_mode_select |->
    ((new_held ^ drive_pattern_register_q) & mask) == 3'h0)
    else $error("ordinary detection without pattern match");
  start_snapshot_a: assert property (start_go |=>
    start_pattern_latch_q == $past(pos_s) && sampling_active_flag_o)
    else $error("start pattern not latched");
  timer_stop_a: assert property (stop_go && !detect |=> state_q == rpd_pkg::RPD_FINAL)
    else $error("stop trigger ignored");
  final_end_a: assert property (state_q == rpd_pkg::RPD_FINAL && tick |=> state_q == rpd_pkg::RPD_IDLE)
    else $error("final comparison did not end sampling");
  pwm_delay_a: assert property (step && ctrl_b_q.sampling_gate_select == rpd_pkg::RPD_GATE_PWM |->
    pwm_on && dly_q[3] == delay_q)
    else $error("sample taken inside settle delay");
  idle_phase_hold_a: assert property (ce_i && state_q == rpd_pkg::RPD_SAMPLE && !start_go &&
    !phase_en[0] |=> held_q[0] == $past(held_q[0]))
    else $error("idle phase sample changed");
  count_reach_a: assert property (step && hit && !ctrl_a_q.detect_mode_select &&
    5'({1'b0, cnt_q} + 5'h01) < need |=> !position_match_irq_o)
    else $error("detection before count reached");
  fall_record_a: assert property (ce_i && pwm_on_q && !pwm_on && hit_held |=> edge_detect_record_q[1])
    else $error("falling edge result not recorded");

endmodule : rpd_detector

/* bench/rpd_sensor_model.sv */
// Behavioural position sensor outputs feeding the three detector pins
`timescale 1ns/1ps
module rpd_sensor_model (
  input  wire logic [2:0] pattern_i,
  output logic            phase_u_o,
  output logic            phase_v_o,
  output logic            phase_w_o
);
  // Pins start low until the bench picks a rotor position
  initial {phase_w_o, phase_v_o, phase_u_o} = 3'h0;
  // Comparator lag keeps pin edges away from core clock edges, as real sensors do
  always @(pattern_i) {phase_w_o, phase_v_o, phase_u_o} <= #7 pattern_i;
endmodule : rpd_sensor_model

/* bench/rotor_position_detector_tb.sv */
// Self-checking bench for the rotor position detector
`timescale 1ns/1ps
`include "rpd_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t value mismatch at line %0d", $time, `__LINE__); end end
module rotor_position_detector_tb;
  typedef struct packed {
    logic [1:0] per;
    logic [3:0] cnt;
    logic       um;
    logic [2:0] pat;
    logic [2:0] p0;
    logic [2:0] p1;
    logic       hit;
  } rpd_row_s;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pins;
  logic        pin_u;
  logic        pin_v;
  logic        pin_w;
  logic [2:0]  pwm;
  logic [2:0]  lower_on;
  logic        tmr2;
  logic        tmr3;
  logic        irq;
  logic        smp;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          comparisons;
  int          n;
  int          div;
  int          cnt;
  int          irq_cnt;
  int          c0;
  // Period, count, mode, expected pattern, pins at start, pins after start, detection
  rpd_row_s rows [8] = '{
    '{2'h0, 4'h1, 1'h0, 3'h5, 3'h5, 3'h5, 1'h1},
    '{2'h1, 4'h4, 1'h0, 3'h3, 3'h3, 3'h3, 1'h1},
    '{2'h2, 4'hF, 1'h0, 3'h6, 3'h6, 3'h6, 1'h1},
    '{2'h3, 4'h8, 1'h0, 3'h1, 3'h1, 3'h1, 1'h1},
    '{2'h0, 4'h2, 1'h0, 3'h2, 3'h4, 3'h4, 1'h0},
    '{2'h0, 4'h0, 1'h0, 3'h7, 3'h7, 3'h7, 1'h1},
    '{2'h1, 4'h3, 1'h1, 3'h0, 3'h2, 3'h5, 1'h1},
    '{2'h0, 4'h2, 1'h1, 3'h0, 3'h4, 3'h4, 1'h0}
  };

  rpd_detector i_rpd_detector (
    .core_clk_i             (clk),
    .rst_i                  (rst),
    .ce_i                   (ce),
    .psel_i                 (psel),
    .penable_i              (penable),
    .pwrite_i               (pwrite),
    .paddr_i                (paddr),
    .pwdata_i               (pwdata),
    .prdata_o               (prdata),
    .pready_o               (pready),
    .pslverr_o              (pslverr),
    .phase_u_position_in_i  (pin_u),
    .phase_v_position_in_i  (pin_v),
    .phase_w_position_in_i  (pin_w),
    .pwm_phase_i            (pwm),
    .lower_on_i             (lower_on),
    .tmr2_evt_i             (tmr2),
    .tmr3_evt_i             (tmr3),
    .position_match_irq_o   (irq),
    .sampling_active_flag_o (smp)
  );

  rpd_sensor_model i_rpd_sensor_model (
    .pattern_i (pins),
    .phase_u_o (pin_u),
    .phase_v_o (pin_v),
    .phase_w_o (pin_w)
  );

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Interrupt pulses counted, so a pulse during a bus cycle is never missed
  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt++;
  end

  // One APB transfer; holds the request until pready is seen at an edge, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Read one register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask : rd_chk

  // Store the control bits first: a start only counts once enable is already set
  task automatic start(input logic [31:0] ca);
    apb(1'b1, `RPD_OFS_CTRL_A, ca);
    apb(1'b1, `RPD_OFS_CTRL_A, ca | (32'h0000_0001 << `RPD_CA_SOFT_START));
  endtask : start

  // Bounded wait for the interrupt; n holds the cycles spent
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq

  // Closing task shared by the main sequence and the watchdog
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: far beyond the longest expected run
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    {rst, ce, psel, penable, pwrite, tmr2, tmr3} = 7'h60;
    {paddr, pwdata, pins, pwm, lower_on} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`RPD_OFS_CTRL_A, {26'h000_0000, `RPD_RST_CTRL_A});
    rd_chk(`RPD_OFS_CTRL_B, {24'h00_0000, `RPD_RST_CTRL_B});
    rd_chk(`RPD_OFS_PATTERN, {29'h0000_0000, `RPD_RST_PATTERN});
    rd_chk(`RPD_OFS_DELAY, {24'h00_0000, `RPD_RST_DELAY});
    apb(1'b1, `RPD_OFS_STATUS, 32'h0000_00FF);
    rd_chk(`RPD_OFS_STATUS, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Table of ordinary and unmatch cases in continuous sampling
    foreach (rows[i]) begin
      div = 4 << rows[i].per;
      cnt = (rows[i].cnt == 4'h0) ? 1 : int'(rows[i].cnt);
      apb(1'b1, `RPD_OFS_CTRL_B, {24'h00_0000, rows[i].per, 2'h1, rows[i].cnt});
      apb(1'b1, `RPD_OFS_PATTERN, {29'h0000_0000, rows[i].pat});
      pins <= rows[i].p0;
      repeat (4) @(posedge clk);
      start({30'h0000_0000, rows[i].um, 1'b1});
      pins <= rows[i].p1;
      wait_irq(cnt * div + 8);
      `CHK(irq, rows[i].hit)
      if (rows[i].hit) begin
        `CHK(n >= (cnt - 1) * div && n <= cnt * div + 4, 1'b1)
        `CHK(smp, 1'b0)
        @(posedge clk);
        `CHK(irq, 1'b0)
      end
      apb(1'b0, `RPD_OFS_STATUS, 32'h0000_0000);
      `CHK(rd[3:0], {~rows[i].hit, rows[i].p0})
      if (!rows[i].hit) begin
        apb(1'b1, `RPD_OFS_CTRL_A, {24'h00_0000, 6'h20, rows[i].um, 1'b1});
        wait_irq(2 * div + 4);
        `CHK({irq, smp}, 2'h0)
      end
    end
    // Timer 2 starts and timer 3 stops a sampling run
    apb(1'b1, `RPD_OFS_CTRL_B, 32'h0000_0011);
    apb(1'b1, `RPD_OFS_PATTERN, 32'h0000_0003);
    pins <= 3'h4;
    apb(1'b1, `RPD_OFS_CTRL_A, 32'h0000_0031);
    tmr2 <= 1'b1;
    @(posedge clk);
    tmr2 <= 1'b0;
    @(posedge clk);
    `CHK(smp, 1'b1)
    tmr3 <= 1'b1;
    @(posedge clk);
    tmr3 <= 1'b0;
    wait_irq(12);
    `CHK({irq, smp}, 2'h0)
    // PWM-on gate with settle delay; common duty on all phases
    apb(1'b1, `RPD_OFS_DELAY, 32'h0000_0005);
    apb(1'b1, `RPD_OFS_CTRL_B, 32'h0000_0002);
    pins <= 3'h3;
    start(32'h0000_0001);
    wait_irq(100);
    `CHK(irq, 1'b0)
    pwm <= 3'h7;
    wait_irq(40);
    `CHK(irq === 1'b1 && n >= 8, 1'b1)
    @(posedge clk);
    pwm <= 3'h0;
    // Held sample hits at both PWM edges, so both records are set
    repeat (2) @(posedge clk);
    apb(1'b0, `RPD_OFS_STATUS, 32'h0000_0000);
    `CHK(rd[5:3], 3'h6)
    // Recount: short PWM pulses never gather four hits in a row
    apb(1'b1, `RPD_OFS_CTRL_B, 32'h0000_0004);
    start(32'h0000_0005);
    apb(1'b0, `RPD_OFS_STATUS, 32'h0000_0000);
    `CHK(rd[5:3], 3'h1)
    c0 = irq_cnt;
    repeat (6) begin
      pwm <= 3'h7;
      repeat (12) @(posedge clk);
      pwm <= 3'h0;
      repeat (4) @(posedge clk);
    end
    `CHK(irq_cnt - c0, 0)
    // Stop with the gate closed: the final ungated compare still detects
    start(32'h0000_0001);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK({pready, smp}, 2'h1)
    ce <= 1'b1;
    c0 = irq_cnt;
    apb(1'b1, `RPD_OFS_CTRL_A, 32'h0000_0081);
    repeat (8) @(posedge clk);
    `CHK(irq_cnt - c0, 1)
    `CHK(smp, 1'b0)
    // Lower gate: only U conducts, so V and W keep their start values
    apb(1'b1, `RPD_OFS_CTRL_B, 32'h0000_0021);
    apb(1'b1, `RPD_OFS_PATTERN, 32'h0000_0005);
    pins <= 3'h4;
    repeat (4) @(posedge clk);
    start(32'h0000_0001);
    pins <= 3'h1;
    wait_irq(40);
    `CHK(irq, 1'b0)
    lower_on <= 3'h1;
    wait_irq(20);
    `CHK(irq === 1'b1 && n >= 6, 1'b1)
    lower_on <= 3'h0;
    // One pin: W differs from the pattern but only U is compared
    apb(1'b1, `RPD_OFS_CTRL_B, 32'h0000_0011);
    start(32'h0000_0009);
    wait_irq(12);
    `CHK(irq, 1'b1)
    // Everything off before a low-power stop; a start without enable is ignored
    apb(1'b1, `RPD_OFS_CTRL_A, 32'h0000_0000);
    apb(1'b1, `RPD_OFS_CTRL_A, 32'h0000_0040);
    `CHK(smp, 1'b0)
    give_verdict();
  end
endmodule : rotor_position_detector_tb
